/* File: tcc_top.sv */
/*
  tcc_top: six-channel counter control with clear source select, counting
  edge select and count clock select, plus the channel counters themselves.
  assumes compare/capture events arrive as same-clock pulses and that an
  outside phase decoder supplies step and direction in phase counting modes.
*/
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tcc_top #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_resetn,
  // register bus
  input  wire tcc_pkg::tcc_avm_req_t i_avm,
  output var  tcc_pkg::tcc_avm_rsp_t o_avm,
  // external clock pins a to d
  input  wire logic [3:0]            i_ext_clock_pin,
  // compare/capture events per channel, bits a,b,c,d
  input  wire logic [5:0][3:0]       i_match_evt,
  // phase decoder step and direction per channel
  input  wire logic [5:0]            i_phase_step,
  input  wire logic [5:0]            i_phase_up,
  // counter wrap pulses
  output var  logic [5:0]            o_overflow,
  output var  logic [5:0]            o_underflow
);
  import tcc_pkg::*;

  if (CNT_W < 2 || CNT_W > 32) begin : g_chk
    $error("tcc_top: CNT_W must be 2 to 32");
  end

  typedef struct packed {
    logic [NCH-1:0][7:0]       ctrl;
    logic [NCH-1:0][5:0]       mode;
    logic [NCH-1:0]            sync;
    logic [NCH-1:0]            start;
    logic [DIV_W-1:0]          div;
    logic [3:0]                pin_s1;
    logic [3:0]                pin_s2;
    logic [3:0]                pin_prev;
    logic [NCH-1:0]            pend;
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [NCH-1:0]            ovf;
    logic [NCH-1:0]            udf;
    tcc_avm_rsp_t              rsp;
  } tcc_st_t;

  localparam tcc_st_t ST_RST = '{rsp: '{readdata: 32'h0, waitrequest: 1'b1}, default: '0};

  tcc_st_t s_q;
  tcc_st_t s_d;

  always_comb begin
    tcc_src_t               src;
    logic                   r;
    logic                   f;
    logic                   tick;
    logic                   up;
    logic                   clr_evt;
    logic                   any_sync;
    logic [2:0]             clr;
    logic [1:0]             edg;
    logic [3:0]             m;
    logic [3:0]             pin_r;
    logic [3:0]             pin_f;
    logic [DIV_W-1:0]       mask;
    logic [NCH-1:0]         own_clr;
    logic [31:0]            rd;
    int                     b;
    src      = SRC_P1;
    r        = 1'b0;
    f        = 1'b0;
    tick     = 1'b0;
    up       = 1'b1;
    clr_evt  = 1'b0;
    any_sync = 1'b0;
    clr      = 3'h0;
    edg      = 2'h0;
    m        = 4'h0;
    pin_r    = 4'h0;
    pin_f    = 4'h0;
    mask     = '0;
    own_clr  = '0;
    rd       = 32'h0;
    b        = 0;
    s_d      = s_q;

    // two flops before the edge detector; the first is read only by the second
    s_d.pin_s1   = i_ext_clock_pin;
    s_d.pin_s2   = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    pin_r        = s_q.pin_s2 & ~s_q.pin_prev;
    pin_f        = ~s_q.pin_s2 & s_q.pin_prev;
    s_d.div      = s_q.div + 12'h001;

    // own clear sources; buffer registers raise no event
    for (int ch = 0; ch < NCH; ch++) begin
      m = i_match_evt[ch];
      if (tcc_wide(ch)) begin
        m[2] = m[2] & ~s_q.mode[ch][MODE_BFA];
        m[3] = m[3] & ~s_q.mode[ch][MODE_BFB];
      end else begin
        m[3:2] = 2'h0;
      end
      clr = s_q.ctrl[ch][CLR_HI:CLR_LO];
      // narrow channels hold bit 7 at zero, so their codes share this decode
      own_clr[ch] = (clr == CLR_A && m[0]) || (clr == CLR_B && m[1]) ||
                    (clr == CLR_C && m[2]) || (clr == CLR_D && m[3]);
    end
    any_sync = |(own_clr & s_q.sync);

    for (int ch = 0; ch < NCH; ch++) begin
      clr     = s_q.ctrl[ch][CLR_HI:CLR_LO];
      clr_evt = own_clr[ch] ||
                ((clr == CLR_SYNC || clr == CLR_SYN2) && s_q.sync[ch] && any_sync);
      src     = tcc_src(ch, s_q.ctrl[ch][PSC_HI:PSC_LO]);
      edg     = s_q.ctrl[ch][EDGE_HI:EDGE_LO];
      up      = 1'b1;
      r       = 1'b0;
      f       = 1'b0;
      case (src)
        SRC_EXTA: begin r = pin_r[0]; f = pin_f[0]; end
        SRC_EXTB: begin r = pin_r[1]; f = pin_f[1]; end
        SRC_EXTC: begin r = pin_r[2]; f = pin_f[2]; end
        SRC_EXTD: begin r = pin_r[3]; f = pin_f[3]; end
        default: begin
          b    = tcc_div_bit(src);
          mask = DIV_W'((1 << b) - 1);
          r    = ((s_q.div & mask) == mask) && !s_q.div[b];
          f    = ((s_q.div & mask) == mask) && s_q.div[b];
        end
      endcase
      if (edg == EDGE_RISE) tick = r;
      else if (edg == EDGE_FALL) tick = f;
      else tick = r | f;
      // the undivided clock and the cascade input take no edge choice
      if (src == SRC_P1) tick = 1'b1;
      if (src == SRC_CASC) begin
        tick = (ch == 1) ? (s_q.ovf[2] | s_q.udf[2]) : (s_q.ovf[5] | s_q.udf[5]);
      end
      if (!tcc_wide(ch) && s_q.mode[ch][3:2] == MODE_PHASE_HI) begin
        tick = i_phase_step[ch];
        up   = i_phase_up[ch];
      end

      s_d.ovf[ch] = 1'b0;
      s_d.udf[ch] = 1'b0;
      // a clear waits for the next count opportunity and replaces that step
      if (s_q.start[ch] && tick) begin
        s_d.pend[ch] = 1'b0;
        if (s_q.pend[ch] || clr_evt) begin
          s_d.cnt[ch] = '0;
        end else if (up) begin
          s_d.cnt[ch] = s_q.cnt[ch] + 1'b1;
          s_d.ovf[ch] = &s_q.cnt[ch];
        end else begin
          s_d.cnt[ch] = s_q.cnt[ch] - 1'b1;
          s_d.udf[ch] = ~|s_q.cnt[ch];
        end
      end else begin
        s_d.pend[ch] = s_q.pend[ch] | clr_evt;
      end
    end

    // read decode
    for (int ch = 0; ch < NCH; ch++) begin
      if (i_avm.address == 8'(REG_CTRL_BASE + REG_STRIDE * ch)) begin
        rd = {24'h0, s_q.ctrl[ch]};
      end else if (i_avm.address == 8'(REG_MODE_BASE + REG_STRIDE * ch)) begin
        rd = {24'h0, MODE_RSV_HI, s_q.mode[ch]};
      end else if (i_avm.address == 8'(REG_CNT_BASE + REG_STRIDE * ch)) begin
        rd = 32'(s_q.cnt[ch]);
      end
    end
    if (i_avm.address == REG_SYNC) begin
      rd = {26'h0, s_q.sync};
    end else if (i_avm.address == REG_START) begin
      rd = {26'h0, s_q.start};
    end

    // one wait cycle; write lands at the edge where waitrequest is seen low
    if (s_q.rsp.waitrequest) begin
      if (i_avm.read || i_avm.write) begin
        s_d.rsp.waitrequest = 1'b0;
        s_d.rsp.readdata    = rd;
      end
    end else begin
      s_d.rsp.waitrequest = 1'b1;
      if (i_avm.write && i_avm.byteenable[0]) begin
        // settings are taken as written, except that narrow channels zero ctrl bit 7 and the mode buffer bits; changing them mid-count is software's hazard
        for (int ch = 0; ch < NCH; ch++) begin
          if (i_avm.address == 8'(REG_CTRL_BASE + REG_STRIDE * ch)) begin
            s_d.ctrl[ch] = i_avm.writedata[7:0];
            if (!tcc_wide(ch)) s_d.ctrl[ch][NARROW_TOP] = 1'b0;
          end else if (i_avm.address == 8'(REG_MODE_BASE + REG_STRIDE * ch)) begin
            s_d.mode[ch] = i_avm.writedata[5:0];
            if (!tcc_wide(ch)) s_d.mode[ch][MODE_BFB:MODE_BFA] = 2'h0;
          end
        end
        if (i_avm.address == REG_SYNC) begin
          s_d.sync = i_avm.writedata[NCH-1:0];
        end else if (i_avm.address == REG_START) begin
          s_d.start = i_avm.writedata[NCH-1:0];
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avm       = s_q.rsp;
  assign o_overflow  = s_q.ovf;
  assign o_underflow = s_q.udf;

endmodule // tcc_top

/* File: tcc_pkg.sv */
/*
  tcc_pkg: register map, field layout, clock source codes and bus carriers
  for the timer count clock and clear control block.
  assumes a single 8-bit byte address space on an Avalon-MM slave port.
*/
package tcc_pkg;

  localparam int NCH = 6;

  // register byte addresses
  localparam logic [7:0] REG_CTRL_BASE = 8'h00;
  localparam logic [7:0] REG_MODE_BASE = 8'h18;
  localparam logic [7:0] REG_SYNC      = 8'h30;
  localparam logic [7:0] REG_START     = 8'h34;
  localparam logic [7:0] REG_CNT_BASE  = 8'h40;
  localparam logic [7:0] REG_STRIDE    = 8'h04;

  // counter control register fields
  localparam int CLR_HI  = 7;
  localparam int CLR_LO  = 5;
  localparam int EDGE_HI = 4;
  localparam int EDGE_LO = 3;
  localparam int PSC_HI  = 2;
  localparam int PSC_LO  = 0;
  localparam int NARROW_TOP = 7;

  // mode register fields
  localparam int MODE_BFA = 4;
  localparam int MODE_BFB = 5;
  localparam logic [1:0] MODE_RSV_HI  = 2'h3;
  localparam logic [1:0] MODE_PHASE_HI = 2'h1;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // clear select codes; narrow channels read as these with bit 2 zero
  localparam logic [2:0] CLR_A    = 3'h1;
  localparam logic [2:0] CLR_B    = 3'h2;
  localparam logic [2:0] CLR_SYNC = 3'h3;
  localparam logic [2:0] CLR_C    = 3'h5;
  localparam logic [2:0] CLR_D    = 3'h6;
  localparam logic [2:0] CLR_SYN2 = 3'h7;

  // edge select codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  // divider bit whose toggling forms each internal clock
  localparam int DIV_W    = 12;
  localparam int DB_P4    = 1;
  localparam int DB_P16   = 3;
  localparam int DB_P64   = 5;
  localparam int DB_P256  = 7;
  localparam int DB_P1024 = 9;
  localparam int DB_P4096 = 11;

  typedef enum logic [3:0] {
    SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_P256, SRC_P1024, SRC_P4096,
    SRC_EXTA, SRC_EXTB, SRC_EXTC, SRC_EXTD, SRC_CASC
  } tcc_src_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } tcc_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } tcc_avm_rsp_t;

  function automatic logic tcc_wide(input int ch);
    return (ch == 0) || (ch == 3);
  endfunction

  // per-channel decode of the prescale select field
  function automatic tcc_src_t tcc_src(input int ch, input logic [2:0] psc);
    tcc_src_t r;
    r = SRC_P1;
    case (psc)
      3'h0: r = SRC_P1;
      3'h1: r = SRC_P4;
      3'h2: r = SRC_P16;
      3'h3: r = SRC_P64;
      3'h4: r = SRC_EXTA;
      3'h5: r = (ch == 3) ? SRC_P1024 : ((ch == 4 || ch == 5) ? SRC_EXTC : SRC_EXTB);
      3'h6: begin
        if (ch == 0 || ch == 2) r = SRC_EXTC;
        else if (ch == 4) r = SRC_P1024;
        else r = SRC_P256;
      end
      default: begin
        if (ch == 0 || ch == 5) r = SRC_EXTD;
        else if (ch == 2) r = SRC_P1024;
        else if (ch == 3) r = SRC_P4096;
        else r = SRC_CASC;
      end
    endcase
    return r;
  endfunction

  function automatic int tcc_div_bit(input tcc_src_t s);
    int b;
    b = DB_P4;
    case (s)
      SRC_P16:   b = DB_P16;
      SRC_P64:   b = DB_P64;
      SRC_P256:  b = DB_P256;
      SRC_P1024: b = DB_P1024;
      SRC_P4096: b = DB_P4096;
      default:   b = DB_P4;
    endcase
    return b;
  endfunction

endpackage

/* File: tcc_top_monitor.sv */
/* tcc_top_monitor: bus answer, read-back and wrap checks on tcc_top.
   assumes a master that holds each request until it is answered. */
`timescale 1ns/1ps
module tcc_top_monitor (
  // watched ports
  input wire logic                  i_core_clk,
  input wire logic                  i_resetn,
  input wire tcc_pkg::tcc_avm_req_t i_avm,
  input wire tcc_pkg::tcc_avm_rsp_t o_avm,
  input wire logic [5:0]            o_overflow,
  input wire logic [5:0]            o_underflow
);
  import tcc_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic       ans_rd;
  logic [7:0] a;
  assign ans_rd = i_avm.read && !o_avm.waitrequest;
  assign a      = i_avm.address;
  sequence s_take; (i_avm.read || i_avm.write) && o_avm.waitrequest; endsequence
  sequence s_ans; !o_avm.waitrequest ##1 o_avm.waitrequest; endsequence
  property p_answer; s_take |=> s_ans; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_first; $rose(i_resetn) |-> o_avm.waitrequest; endproperty
  a_first: assert property (p_first) else $error("answer at reset exit");
  property p_narrow; ans_rd && a inside {8'h04, 8'h08, 8'h10, 8'h14} |-> !o_avm.readdata[7]; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow top bit set");
  property p_upper; ans_rd |-> o_avm.readdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmapped; ans_rd && a >= 8'h58 |-> o_avm.readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_mode; ans_rd && a inside {[8'h18:8'h2c]} && a[1:0] == 2'h0 |-> o_avm.readdata[7:6] == 2'h3;
  endproperty
  a_mode: assert property (p_mode) else $error("mode top bits not one");
  property p_sync; ans_rd && (a == 8'h30 || a == 8'h34) |-> o_avm.readdata[31:6] == 26'h0; endproperty
  a_sync: assert property (p_sync) else $error("sync or start wide");
  property p_pulse; (o_overflow & $past(o_overflow)) == 6'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("wrap pulse too long");
  property p_excl; (o_overflow & o_underflow) == 6'h0; endproperty
  a_excl: assert property (p_excl) else $error("both wraps at once");
endmodule // tcc_top_monitor
bind tcc_top tcc_top_monitor tcc_top_monitor_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_avm(i_avm), .o_avm(o_avm), .o_overflow(o_overflow), .o_underflow(o_underflow));

/* File: tcc_top_bench.sv */
/* tcc_top_bench: register, clock select, clear and phase scenarios.
   assumes an 8-bit counter build so wraps come quickly. */
`timescale 1ns/1ps
module tcc_top_bench;
  import tcc_pkg::*;
  logic clk, resetn;
  tcc_avm_req_t req;
  tcc_avm_rsp_t rsp;
  logic [3:0] pin;
  logic [5:0][3:0] evt;
  logic [5:0] step, up, ovf, unf;
  logic [31:0] rd, c0;
  int num_errors, n_tests, i;
  tcc_top #(.CNT_W(8)) tcc_top_i (.i_core_clk(clk), .i_resetn(resetn), .i_avm(req), .o_avm(rsp),
    .i_ext_clock_pin(pin), .i_match_evt(evt), .i_phase_step(step), .i_phase_up(up),
    .o_overflow(ovf), .o_underflow(unf));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    // no cycle limit here: only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic rst();
    resetn <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
  endtask
  // counter delta between two reads taken exactly k cycles apart
  task automatic rate(input int ch, input logic [7:0] c, input int k, input logic [7:0] e);
    bus(1, REG_CTRL_BASE + 8'(4 * ch), {24'h0, c});
    bus(0, REG_CNT_BASE + 8'(4 * ch), 0);
    c0 = rd;
    cyc(k - 3);
    bus(0, REG_CNT_BASE + 8'(4 * ch), 0);
    chk("rate", {24'h0, e}, {24'h0, rd[7:0] - c0[7:0]});
  endtask
  // three rising and three falling pin edges, four cycles apart
  task automatic ext(input int p, input logic [7:0] c, input logic [7:0] e);
    bus(1, REG_CTRL_BASE, {24'h0, c});
    bus(0, REG_CNT_BASE, 0);
    c0 = rd;
    for (int j = 0; j < 6; j++) begin
      pin[p] <= !pin[p];
      cyc(4);
    end
    cyc(4);
    bus(0, REG_CNT_BASE, 0);
    chk("ext", {24'h0, e}, {24'h0, rd[7:0] - c0[7:0]});
  endtask
  // channel 3 clears on its own a event so sync cases have a source
  task automatic clr(input int ch, input logic [7:0] c, input logic [7:0] m, input logic [5:0] s,
                     input int ec, input logic [3:0] eb, input logic e);
    rst();
    bus(1, REG_CTRL_BASE + 8'h0c, 32'h20);
    bus(1, REG_CTRL_BASE + 8'(4 * ch), {24'h0, c});
    bus(1, REG_MODE_BASE + 8'(4 * ch), {24'h0, m});
    bus(1, REG_SYNC, {26'h0, s});
    bus(1, REG_START, 32'h3f);
    cyc(100);
    evt[ec] <= eb;
    cyc(1);
    evt[ec] <= 4'h0;
    cyc(4);
    bus(0, REG_CNT_BASE + 8'(4 * ch), 0);
    chk("cleared", {31'h0, e}, {31'h0, rd[7:0] < 8'd16});
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    resetn = 0; req = '0; pin = 0; evt = '0; step = 0; up = 0;
    num_errors = 0; n_tests = 0;
    cyc(10);
    resetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      bus(0, REG_CTRL_BASE + 8'(4 * i), 0); chk("ctrl reset", 32'h0, rd);
      bus(0, REG_MODE_BASE + 8'(4 * i), 0); chk("mode reset", 32'hc0, rd);
    end
    bus(0, REG_SYNC, 0); chk("sync reset", 32'h0, rd);
    bus(0, 8'h80, 0); chk("unmapped", 32'h0, rd);
    bus(1, REG_CTRL_BASE, 32'h55); bus(0, REG_CTRL_BASE, 0); chk("no lane", 32'h0, rd);
    req.byteenable <= 4'hf;
    bus(1, REG_CTRL_BASE, 32'h55); bus(0, REG_CTRL_BASE, 0); chk("ctrl rw", 32'h55, rd);
    for (i = 0; i < 6; i++) begin
      bus(1, REG_CTRL_BASE + 8'(4 * i), 32'hff); bus(0, REG_CTRL_BASE + 8'(4 * i), 0);
      chk("ctrl top", (i == 0 || i == 3) ? 32'hff : 32'h7f, rd);
      bus(1, REG_CTRL_BASE + 8'(4 * i), 32'h0);
    end
    bus(1, REG_START, 32'h3f);
    for (i = 0; i < 4; i++) rate(0, 8'(i), 128, 8'(128 >> (2 * i)));
    rate(0, 8'h09, 128, 8'd32);
    rate(0, 8'h11, 128, 8'd64);
    rate(0, 8'h10, 128, 8'd128);
    rate(1, 8'h06, 512, 8'd2);
    rate(3, 8'h07, 4096, 8'd1);
    rate(1, 8'h17, 512, 8'd2);
    for (i = 0; i < 4; i++) ext(i, 8'(4 + i), 8'd3);
    ext(0, 8'h0c, 8'd3);
    ext(0, 8'h14, 8'd6);
    clr(0, 8'h20, 8'h00, 6'h00, 0, 4'h1, 1'b1);
    clr(0, 8'h40, 8'h00, 6'h00, 0, 4'h2, 1'b1);
    clr(0, 8'h80, 8'h00, 6'h00, 0, 4'hf, 1'b0);
    clr(0, 8'ha0, 8'h00, 6'h00, 0, 4'h4, 1'b1);
    clr(0, 8'ha0, 8'h10, 6'h00, 0, 4'h4, 1'b0);
    clr(3, 8'hc0, 8'h00, 6'h00, 3, 4'h8, 1'b1);
    clr(3, 8'hc0, 8'h20, 6'h00, 3, 4'h8, 1'b0);
    clr(1, 8'h20, 8'h00, 6'h00, 1, 4'h2, 1'b0);
    clr(1, 8'h40, 8'h00, 6'h00, 1, 4'h2, 1'b1);
    clr(0, 8'h60, 8'h00, 6'h09, 3, 4'h1, 1'b1);
    clr(0, 8'he0, 8'h00, 6'h08, 3, 4'h1, 1'b0);
    clr(1, 8'h60, 8'h00, 6'h0a, 3, 4'h1, 1'b1);
    // phase mode on channel 1: one down step from zero wraps
    rst();
    bus(1, REG_MODE_BASE + 8'h04, 32'h4);
    bus(1, REG_START, 32'h2);
    step[1] <= 1'b1;
    cyc(1);
    step[1] <= 1'b0;
    c0 = 0;
    repeat (4) begin
      @(posedge clk);
      if (unf[1] === 1'b1) c0 = 1;
    end
    chk("underflow", 32'h1, c0);
    bus(0, REG_CNT_BASE + 8'h04, 0); chk("phase count", 32'hff, rd);
    // one up step from all ones wraps forward
    step[1] <= 1'b1;
    up[1] <= 1'b1;
    cyc(1);
    step[1] <= 1'b0;
    c0 = 0;
    repeat (4) begin
      @(posedge clk);
      if (ovf[1] === 1'b1) c0 = 1;
    end
    chk("overflow", 32'h1, c0);
    test_done();
  end
  initial begin
    cyc(60000);
    num_errors++;
    test_done();
  end
endmodule // tcc_top_bench
